//--- rtl/wsc_pkg.sv
// package of constants for the cellular module sideband control block
package wsc_pkg;
    // clock rate of the internal reference clock
    localparam int unsigned CLK_HZ = 125000000;
    // wake pulse length in milliseconds
    localparam int unsigned WAKE_PULSE_MS = 1000;
    // card supply delay in milliseconds
    localparam int unsigned CARD_DELAY_MS = 2000;
    // cycle counts derived from the rate
    localparam int unsigned WAKE_CYCLES = (CLK_HZ / 1000) * WAKE_PULSE_MS;
    localparam int unsigned CARD_CYCLES = (CLK_HZ / 1000) * CARD_DELAY_MS;
    // timer width, wide enough for the longest count
    localparam int unsigned TMR_W = 28;
    // antenna code width and band groups
    localparam int unsigned ANT_W = 4;
    localparam int unsigned BAND_W = 2;
    // values after reset
    localparam logic [ANT_W-1:0] ANT_RESET = 4'h0;
    // antenna code per band group after reset, bit 0 is the first control line
    localparam logic [ANT_W-1:0] ANT_BAND0 = 4'h0;
    localparam logic [ANT_W-1:0] ANT_BAND1 = 4'h2;
    localparam logic [ANT_W-1:0] ANT_BAND2 = 4'h1;
    localparam logic [ANT_W-1:0] ANT_BAND3 = 4'h3;
    localparam logic [1:0] SYNC_RESET_LO = 2'h0;
    localparam logic [1:0] SYNC_RESET_HI = 2'h3;
    // tuner modes
    typedef enum logic
    {
        WSC_TUNER_LAPTOP,
        WSC_TUNER_TABLET
    } wsc_tuner_e;
endpackage

//--- rtl/wsc_top.sv
// sideband control logic of the cellular module: wake, power back-off, card, antenna, reset
`timescale 1ns/100ps
module wsc_top
#(
    // pulse and delay lengths in clock cycles, shortened only in simulation
    parameter int unsigned WAKE_LEN = wsc_pkg::WAKE_CYCLES,
    parameter int unsigned CARD_LEN = wsc_pkg::CARD_CYCLES
)
(
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic RESET_N,
    input wire logic WAKE_REQ,
    output logic HOST_WAKE_OUT_N_O,
    output logic HOST_WAKE_OUT_N_OE,
    input wire logic TX_POWER_REDUCE_IN_N,
    input wire logic LIMIT_VALID,
    input wire logic [7:0] LIMIT_VALUE,
    output logic BACKOFF_ACTIVE,
    output logic [7:0] TX_POWER_LIMIT,
    output logic BACKOFF_EVENT,
    input wire logic CARD_PRESENT_IN,
    output logic CARD_INSERT_EVENT,
    output logic CARD_REMOVE_EVENT,
    output logic CARD_PRESENT,
    output logic CARD_SUPPLY_EN,
    input wire logic ANT_TABLE_WE,
    input wire logic [wsc_pkg::BAND_W-1:0] ANT_TABLE_ADDR,
    input wire logic [wsc_pkg::ANT_W-1:0] ANT_TABLE_DATA,
    input wire logic [wsc_pkg::BAND_W-1:0] BAND_GROUP,
    output logic [wsc_pkg::ANT_W-1:0] ANTENNA_CODE_OUT,
    input wire logic TUNER_MODE_IN,
    output wsc_pkg::wsc_tuner_e TUNER_MODE_SELECT,
    input wire logic FULL_CARD_POWER_OFF_IN_N,
    output logic MODULE_POWER_ON
);
    import wsc_pkg::*;

    // internal reset: block reset or hard reset pin, both asynchronous
    logic rst;
    assign rst = RESET | ~RESET_N;

    // synchroniser stages: bit 1 first flop, bit 0 second flop
    logic [1:0] red_sync_r; // power reduce, idles high
    logic [1:0] card_sync_r; // card detect
    logic [1:0] tuner_sync_r; // tuner mode
    logic [1:0] poff_sync_r; // power-off input
    logic red_q_r; // previous synced power reduce
    logic card_q_r; // previous synced card detect

    // two-flop synchronisers on the power reduce, card detect, tuner mode and power-off inputs
    always_ff @(posedge MCLK or posedge rst)
    begin
        if (rst)
        begin
            red_sync_r <= SYNC_RESET_HI;
            card_sync_r <= SYNC_RESET_LO;
            tuner_sync_r <= SYNC_RESET_LO;
            poff_sync_r <= SYNC_RESET_LO;
            red_q_r <= 1'b1;
            card_q_r <= 1'b0;
        end
        else
        begin
            red_sync_r <= {TX_POWER_REDUCE_IN_N, red_sync_r[1]};
            card_sync_r <= {CARD_PRESENT_IN, card_sync_r[1]};
            tuner_sync_r <= {TUNER_MODE_IN, tuner_sync_r[1]};
            poff_sync_r <= {FULL_CARD_POWER_OFF_IN_N, poff_sync_r[1]};
            red_q_r <= red_sync_r[0];
            card_q_r <= card_sync_r[0];
        end
    end

    // synced levels, read only from the second flop
    logic red_n;
    logic card_in;
    logic power_on;
    assign red_n = red_sync_r[0];
    assign card_in = card_sync_r[0];
    assign power_on = poff_sync_r[0];

    // state registers and next values
    logic [TMR_W-1:0] wake_cnt_r, wake_cnt_nxt; // wake pulse timer
    logic [TMR_W-1:0] card_cnt_r, card_cnt_nxt; // card supply delay timer
    logic supply_r, supply_nxt; // card supply enable
    logic [7:0] limit_r, limit_nxt; // applied power limit
    logic ev_red_r, ev_red_nxt; // back-off event pulse
    logic ev_ins_r, ev_ins_nxt; // insertion event pulse
    logic ev_rem_r, ev_rem_nxt; // removal event pulse
    logic [ANT_W-1:0] ant_tbl_r [2**BAND_W]; // factory antenna table
    logic [ANT_W-1:0] ant_r, ant_nxt; // driven antenna code
    logic tuner_r, tuner_nxt; // tuner mode

    // next-state logic for all timers, events and registered outputs
    always_comb
    begin
        wake_cnt_nxt = wake_cnt_r;
        card_cnt_nxt = card_cnt_r;
        supply_nxt = supply_r;
        limit_nxt = limit_r;
        ev_red_nxt = ~red_n & red_q_r;
        ev_ins_nxt = card_in & ~card_q_r;
        ev_rem_nxt = ~card_in & card_q_r;
        ant_nxt = ant_tbl_r[BAND_GROUP];
        tuner_nxt = tuner_sync_r[0];
        // wake pulse: restart on request, count down otherwise
        if (!power_on)
            wake_cnt_nxt = '0;
        else if (WAKE_REQ)
            wake_cnt_nxt = TMR_W'(WAKE_LEN);
        else if (wake_cnt_r != '0)
            wake_cnt_nxt = wake_cnt_r - 1'b1;
        // card supply delay: restart on insertion, drop on removal
        if (!power_on || !card_in)
        begin
            card_cnt_nxt = '0;
            supply_nxt = 1'b0;
        end
        else if (ev_ins_nxt)
        begin
            card_cnt_nxt = TMR_W'(CARD_LEN);
            supply_nxt = 1'b0;
        end
        else if (card_cnt_r > TMR_W'(1))
            card_cnt_nxt = card_cnt_r - 1'b1;
        else if (card_cnt_r == TMR_W'(1))
        begin
            card_cnt_nxt = '0;
            supply_nxt = 1'b1;
        end
        // power limit taken only while back-off is asserted
        if (!red_n && LIMIT_VALID)
            limit_nxt = LIMIT_VALUE;
    end

    // state registers
    always_ff @(posedge MCLK or posedge rst)
    begin
        if (rst)
        begin
            wake_cnt_r <= '0;
            card_cnt_r <= '0;
            supply_r <= 1'b0;
            limit_r <= 8'h00;
            ev_red_r <= 1'b0;
            ev_ins_r <= 1'b0;
            ev_rem_r <= 1'b0;
            ant_r <= ANT_RESET;
            tuner_r <= 1'b0;
        end
        else
        begin
            wake_cnt_r <= wake_cnt_nxt;
            card_cnt_r <= card_cnt_nxt;
            supply_r <= supply_nxt;
            limit_r <= limit_nxt;
            ev_red_r <= ev_red_nxt;
            ev_ins_r <= ev_ins_nxt;
            ev_rem_r <= ev_rem_nxt;
            ant_r <= ant_nxt;
            tuner_r <= tuner_nxt;
        end
    end

    // factory table: reset to the default band mapping, writable per band
    always_ff @(posedge MCLK or posedge rst)
    begin
        if (rst)
        begin
            ant_tbl_r[0] <= ANT_BAND0; // 880-960 MHz, both lines low
            ant_tbl_r[1] <= ANT_BAND1; // 791-894 MHz, second line high
            ant_tbl_r[2] <= ANT_BAND2; // 746-787 MHz, first line high
            ant_tbl_r[3] <= ANT_BAND3; // 704-746 MHz, both lines high
        end
        else if (ANT_TABLE_WE)
            ant_tbl_r[ANT_TABLE_ADDR] <= ANT_TABLE_DATA;
    end

    // open-drain wake: drive low only, otherwise release
    assign HOST_WAKE_OUT_N_O = 1'b0;
    assign HOST_WAKE_OUT_N_OE = (wake_cnt_r != '0);
    assign BACKOFF_ACTIVE = ~red_n & power_on;
    assign TX_POWER_LIMIT = limit_r;
    assign BACKOFF_EVENT = ev_red_r;
    assign CARD_INSERT_EVENT = ev_ins_r;
    assign CARD_REMOVE_EVENT = ev_rem_r;
    assign CARD_PRESENT = card_in;
    assign CARD_SUPPLY_EN = supply_r;
    assign ANTENNA_CODE_OUT = ant_r;
    assign TUNER_MODE_SELECT = wsc_tuner_e'(tuner_r);
    assign MODULE_POWER_ON = power_on;

    // wake pulse lasts while counter nonzero, starts right after request
    property p_wake_start;
        @(posedge MCLK) disable iff (rst)
        (WAKE_REQ && power_on) |=> HOST_WAKE_OUT_N_OE;
    endproperty
    a_wake_start: assert property (p_wake_start) else $error("wake pulse not started");

    // open drain never drives high
    property p_wake_od;
        @(posedge MCLK) disable iff (rst)
        HOST_WAKE_OUT_N_O == 1'b0;
    endproperty
    a_wake_od: assert property (p_wake_od) else $error("wake line driven high");

    // a wake countdown ends in release
    property p_wake_end;
        @(posedge MCLK) disable iff (rst)
        (wake_cnt_r == TMR_W'(1) && !WAKE_REQ) |=> !HOST_WAKE_OUT_N_OE;
    endproperty
    a_wake_end: assert property (p_wake_end) else $error("wake not released");

    // insertion event follows a rising synced card level
    property p_ins;
        @(posedge MCLK) disable iff (rst)
        $rose(card_in) |=> CARD_INSERT_EVENT;
    endproperty
    a_ins: assert property (p_ins) else $error("insert event missing");

    // removal event follows a falling synced card level
    property p_rem;
        @(posedge MCLK) disable iff (rst)
        $fell(card_in) |=> CARD_REMOVE_EVENT && !CARD_SUPPLY_EN;
    endproperty
    a_rem: assert property (p_rem) else $error("remove event missing");

    // supply never rises without a full delay counted down
    property p_supply;
        @(posedge MCLK) disable iff (rst)
        $rose(CARD_SUPPLY_EN) |-> $past(card_cnt_r) == TMR_W'(1);
    endproperty
    a_supply: assert property (p_supply) else $error("supply early");

    // back-off event on falling power reduce
    property p_backoff_ev;
        @(posedge MCLK) disable iff (rst)
        $fell(red_n) |=> BACKOFF_EVENT;
    endproperty
    a_backoff_ev: assert property (p_backoff_ev) else $error("backoff event missing");

    // limit only changes while back-off asserted
    property p_limit;
        @(posedge MCLK) disable iff (rst)
        red_n |=> $stable(TX_POWER_LIMIT);
    endproperty
    a_limit: assert property (p_limit) else $error("limit changed without backoff");

    // powered off holds supply and wake quiet
    property p_poff;
        @(posedge MCLK) disable iff (rst)
        !power_on |=> !CARD_SUPPLY_EN && !HOST_WAKE_OUT_N_OE;
    endproperty
    a_poff: assert property (p_poff) else $error("activity while off");
endmodule

//--- bench/wsc_host_model.sv
// host platform side: wake line pull-up and wake detection
`timescale 1ns/100ps
module wsc_host_model
(
    input wire logic mclk,
    input wire logic wake_o,
    input wire logic wake_oe,
    output logic wake_line,
    output logic host_awake
);
    // open drain line, host resistor pulls it high when released
    assign wake_line = wake_oe ? wake_o : 1'b1;
    // host powers itself up once the line is seen low
    initial host_awake = 1'b0;
    always @(posedge mclk)
    begin
        if (wake_line === 1'b0)
        begin
            host_awake <= 1'b1;
        end
    end
endmodule

//--- bench/wsc_top_bench.sv
// self-checking bench of the sideband control block
`timescale 1ns/100ps
module wsc_top_bench;
    import wsc_pkg::*;
    // stimulus and observed signals
    logic mclk, rst, rst_n, wreq, red_n, lim_v, card, twe, tun, pwr_n;
    // shortened wake pulse and card supply delay, in clock cycles
    localparam int T_WAKE = 200;
    localparam int T_CARD = 300;
    logic [7:0] lim_d, limit;
    logic [BAND_W-1:0] taddr, band;
    logic [ANT_W-1:0] tdata, ant;
    logic wk_o, wk_oe, bo_act, bo_ev, ins_ev, rem_ev, pres, supply, pwr_on, wline, awake;
    wsc_tuner_e tmode;
    // mismatch, comparison and event counters
    int n_errors = 0;
    int checked = 0;
    int n_bo = 0;
    int n_ins = 0;
    int n_rem = 0;
    wsc_top #(.WAKE_LEN(T_WAKE), .CARD_LEN(T_CARD)) dut (.MCLK(mclk), .RESET(rst),
        .RESET_N(rst_n), .WAKE_REQ(wreq),
        .HOST_WAKE_OUT_N_O(wk_o), .HOST_WAKE_OUT_N_OE(wk_oe), .TX_POWER_REDUCE_IN_N(red_n),
        .LIMIT_VALID(lim_v), .LIMIT_VALUE(lim_d), .BACKOFF_ACTIVE(bo_act),
        .TX_POWER_LIMIT(limit), .BACKOFF_EVENT(bo_ev), .CARD_PRESENT_IN(card),
        .CARD_INSERT_EVENT(ins_ev), .CARD_REMOVE_EVENT(rem_ev), .CARD_PRESENT(pres),
        .CARD_SUPPLY_EN(supply), .ANT_TABLE_WE(twe), .ANT_TABLE_ADDR(taddr),
        .ANT_TABLE_DATA(tdata), .BAND_GROUP(band), .ANTENNA_CODE_OUT(ant),
        .TUNER_MODE_IN(tun), .TUNER_MODE_SELECT(tmode),
        .FULL_CARD_POWER_OFF_IN_N(pwr_n), .MODULE_POWER_ON(pwr_on));
    wsc_host_model host (.mclk(mclk), .wake_o(wk_o), .wake_oe(wk_oe), .wake_line(wline),
        .host_awake(awake));
    // clock of 8 ns
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // count one-cycle event pulses mid-cycle, where they are settled
    always @(negedge mclk)
    begin
        n_bo <= n_bo + int'(bo_ev === 1'b1);
        n_ins <= n_ins + int'(ins_ev === 1'b1);
        n_rem <= n_rem + int'(rem_ev === 1'b1);
    end
    // compare and report
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // wait n falling edges, where outputs are settled
    task automatic nc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // one-cycle wake request
    task automatic wake();
        @(posedge mclk);
        wreq <= 1'b1;
        @(posedge mclk);
        wreq <= 1'b0;
    endtask
    // default band codes, then a reprogrammed table
    task automatic t_ant();
        for (int b = 0; b < 4; b++)
        begin
            @(posedge mclk);
            band <= BAND_W'(b);
            nc(2);
            chk("antenna default", 8'({b[0], b[1]}), 8'(ant));
            @(posedge mclk);
            twe <= 1'b1;
            taddr <= BAND_W'(b);
            tdata <= ANT_W'(b) ^ 4'ha;
            @(posedge mclk);
            twe <= 1'b0;
            nc(2);
            chk("antenna table", 8'(b ^ 10), 8'(ant));
        end
    endtask
    // tuner pin high then low
    task automatic t_tuner();
        for (int v = 1; v >= 0; v--)
        begin
            @(posedge mclk);
            tun <= 1'(v);
            nc(4);
            chk("tuner mode", 8'(v), 8'(tmode));
        end
    endtask
    // back-off, limits back to back, refused limit
    task automatic t_backoff();
        @(posedge mclk);
        red_n <= 1'b0;
        nc(1);
        chk("backoff unsynced", 8'h00, 8'(bo_act));
        nc(4);
        chk("backoff on", 8'h01, 8'(bo_act));
        chk("backoff events", 8'h01, 8'(n_bo));
        @(posedge mclk);
        lim_v <= 1'b1;
        lim_d <= 8'h5a;
        @(posedge mclk);
        lim_d <= 8'h3c;
        @(posedge mclk);
        lim_v <= 1'b0;
        nc(1);
        chk("limit", 8'h3c, limit);
        @(posedge mclk);
        red_n <= 1'b1;
        nc(5);
        chk("backoff off", 8'h00, 8'(bo_act));
        @(posedge mclk);
        lim_v <= 1'b1;
        lim_d <= 8'h77;
        @(posedge mclk);
        lim_v <= 1'b0;
        nc(2);
        chk("limit refused", 8'h3c, limit);
    endtask
    // insertion, delayed supply, removal
    task automatic t_card();
        @(posedge mclk);
        card <= 1'b1;
        nc(6);
        chk("card present", 8'h01, 8'(pres));
        chk("insert events", 8'h01, 8'(n_ins));
        nc(T_CARD - 3);
        chk("supply early", 8'h00, 8'(supply));
        nc(1);
        chk("supply on", 8'h01, 8'(supply));
        @(posedge mclk);
        card <= 1'b0;
        nc(6);
        chk("card absent", 8'h00, 8'(pres));
        chk("supply removed", 8'h00, 8'(supply));
        chk("remove events", 8'h01, 8'(n_rem));
    endtask
    // wake pulse, hard reset, power off
    task automatic t_wake();
        wake();
        nc(1);
        chk("wake drive", 8'h01, 8'(wk_oe));
        chk("wake line", 8'h00, 8'(wline));
        nc(T_WAKE - 1);
        chk("wake held", 8'h00, 8'(wline));
        chk("host awake", 8'h01, 8'(awake));
        nc(1);
        chk("wake released", 8'h01, 8'(wline));
        wake();
        @(posedge mclk);
        rst_n <= 1'b0;
        nc(1);
        chk("hard reset wake", 8'h00, 8'(wk_oe));
        chk("hard reset limit", 8'h00, limit);
        @(posedge mclk);
        rst_n <= 1'b1;
        nc(4);
        @(posedge mclk);
        pwr_n <= 1'b0;
        nc(4);
        chk("powered off", 8'h00, 8'(pwr_on));
        wake();
        nc(2);
        chk("wake refused", 8'h00, 8'(wk_oe));
    endtask
    // print counts and verdict, end the run
    task automatic finish_test();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
        begin
            $display("TB: PASS");
        end
        else
        begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // cut a hang short well past the expected run length
    initial
    begin
        #160000;
        n_errors++;
        finish_test();
    end
    // main sequence
    initial
    begin
        {rst, rst_n, wreq, red_n, lim_v, card, twe, tun, pwr_n} = 9'h1a0;
        {lim_d, taddr, tdata, band} = '0;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        nc(1);
        chk("reset wake", 8'h00, 8'(wk_oe));
        chk("reset power", 8'h00, 8'(pwr_on));
        @(posedge mclk);
        pwr_n <= 1'b1;
        nc(4);
        chk("powered on", 8'h01, 8'(pwr_on));
        t_ant();
        t_tuner();
        t_backoff();
        t_card();
        t_wake();
        finish_test();
    end
endmodule
